/* verification/testbench.sv */
// self-checking testbench for the vacuum condition monitor
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t got %h expected %h", $time, got, exp); end end
module testbench;
  logic aclk, aresetn, suction_pin, iolink_mode, vent;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] error_code, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [9:0] ceiling;
  logic [1:0] resp;
  wire logic [9:0] vacuum_mbar;
  wire logic valve_suction_r, status_yellow_r, menu_abort_r;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [7:0] error_display_r;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int lows;
  logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] rv [7] = '{32'h0000_0005, 32'h0032_0258, 32'h0032_01F4, 32'h0000_03E8,
    32'h0000_00FA, 32'h0000_0000, 32'h0000_0000};

  // one ms is ten clocks so the long windows stay short
  vcm_monitor #(.MS_CYCLES(15'h000A)) u_vcm_monitor (
    .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .suction_pin(suction_pin), .blowoff_pin(1'h0),
    .vacuum_mbar(vacuum_mbar), .iolink_mode(iolink_mode), .error_code(error_code),
    .valve_suction_r(valve_suction_r), .valve_blowoff_r(), .status_yellow_r(status_yellow_r),
    .error_display_r(error_display_r), .menu_abort_r(menu_abort_r),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  vcm_plant u_vcm_plant (.aclk(aclk), .aresetn(aresetn), .valve_on(valve_suction_r),
    .vent(vent), .ceiling(ceiling), .vacuum_mbar(vacuum_mbar));

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok = 1'h0, w_ok = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task automatic rdreg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic suck(input logic on, input logic leak, input int n);
    suction_pin <= on;
    vent <= leak;
    repeat (n * 10) @(posedge aclk);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    {aresetn, suction_pin, iolink_mode, s_axi_awvalid, s_axi_wvalid} = 5'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {error_code, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    ceiling = 10'h3FF;
    vent = 1'h1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      rdreg(ra[i], rd, resp);
      `CHK(rd, rv[i])
    end
    done("reset values");
    rdreg(8'h40, rd, resp);
    `CHK({resp, rd}, {2'h2, 32'h0000_0000})
    wr(8'h40, 32'h0000_0001, resp);
    `CHK(resp, 2'h2)
    wr(8'h18, 32'h0000_00FF, resp);
    rdreg(8'h18, rd, resp);
    `CHK({resp, rd}, {2'h0, 32'h0000_0000})
    wr(8'h0C, 32'h0000_2707, resp);
    `CHK(resp, 2'h2)
    rdreg(8'h0C, rd, resp);
    `CHK(rd, 32'h0000_03E8)
    wr(8'h0C, 32'h0000_2706, resp);
    rdreg(8'h0C, rd, resp);
    `CHK({resp, rd}, {2'h0, 32'h0000_2706})
    done("refusals");
    error_code <= 8'h05;
    repeat (3) @(posedge aclk);
    `CHK(error_display_r, 8'h05)
    rdreg(8'h2C, rd, resp);
    `CHK(rd, 32'h0000_0005)
    error_code <= 8'h00;
    done("error code");
    iolink_mode <= 1'h1;
    wr(8'h0C, 32'h0000_0005, resp);
    suck(1'h1, 1'h0, 150);
    suck(1'h0, 1'h1, 30);
    rdreg(8'h1C, rd, resp);
    // vacuum climbs one mbar a clock: 500 mbar in 50 ms, 100 more in 10 ms
    `CHK(rd[15:0] >= 16'd49 && rd[15:0] <= 16'd51, 1'h1)
    `CHK(rd[31:16] >= 16'd9 && rd[31:16] <= 16'd11, 1'h1)
    rdreg(8'h18, rd, resp);
    `CHK({rd[7], rd[2], status_yellow_r}, 3'h7)
    wr(8'h00, 32'h0000_000D, resp);
    repeat (3) @(posedge aclk);
    rdreg(8'h0C, rd, resp);
    `CHK(rd >= 32'd11 && rd <= 32'd14, 1'h1)
    done("evacuation times");
    wr(8'h0C, 32'h0000_0000, resp);
    ceiling <= 10'h226;
    suck(1'h1, 1'h0, 80);
    rdreg(8'h18, rd, resp);
    `CHK({rd[1], rd[2]}, 2'h0)
    suck(1'h0, 1'h1, 5);
    rdreg(8'h18, rd, resp);
    `CHK({rd[7], rd[1], status_yellow_r}, 3'h7)
    ceiling <= 10'h3FF;
    suck(1'h1, 1'h0, 5);
    rdreg(8'h18, rd, resp);
    `CHK(rd[1], 1'h0)
    rdreg(8'h24, rd, resp);
    `CHK(rd[7:0] != 8'h00 && rd[7:0] <= 8'd100, 1'h1)
    suck(1'h0, 1'h1, 30);
    done("threshold missed");
    // leaky circuit makes the valve chatter until protection trips
    suck(1'h1, 1'h1, 100);
    `CHK(valve_suction_r, 1'h1)
    rdreg(8'h18, rd, resp);
    `CHK({rd[5], rd[0], rd[7]}, 3'h7)
    suck(1'h0, 1'h1, 20);
    done("switching trip");
    iolink_mode <= 1'h0;
    suck(1'h1, 1'h1, 100);
    `CHK({valve_suction_r, status_yellow_r}, 2'h2)
    rdreg(8'h18, rd, resp);
    `CHK(rd[5], 1'h1)
    suck(1'h0, 1'h1, 20);
    done("standard io trip");
    iolink_mode <= 1'h1;
    wr(8'h00, 32'h0000_0007, resp);
    suck(1'h1, 1'h1, 100);
    lows = 0;
    repeat (200) @(posedge aclk) if (!valve_suction_r) lows++;
    `CHK(lows != 0, 1'h1)
    rdreg(8'h18, rd, resp);
    `CHK(rd[5], 1'h0)
    suck(1'h0, 1'h1, 20);
    done("no fallback");
    suck(1'h1, 1'h0, 320);
    rdreg(8'h18, rd, resp);
    `CHK({rd[3], rd[5]}, 2'h2)
    rdreg(8'h20, rd, resp);
    `CHK(rd[15:0] >= 16'd120 && rd[15:0] <= 16'd170, 1'h1)
    done("leakage");
    wrap_up();
  end
endmodule // testbench
`default_nettype wire

/* verification/vcm_monitor_props.sv */
// port-level assertion checker for the vacuum condition monitor
`timescale 1ns/1ns
`default_nettype none
module vcm_monitor_props (
  // clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // process side
  input wire logic suction_pin,
  input wire logic iolink_mode,
  input wire logic [7:0] error_code,
  input wire logic valve_suction_r,
  input wire logic status_yellow_r,
  input wire logic [7:0] error_display_r,
  input wire logic menu_abort_r,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_err_display:
    assert property ($past(ce) |-> error_display_r == $past(error_code))
    else $error("error display does not follow the error code");
  a_menu_abort:
    assert property (menu_abort_r == (error_display_r != 8'h00 && $past(error_display_r) == 8'h00))
    else $error("menu abort pulse does not match a new error");
  a_yellow_gated:
    assert property (!$past(iolink_mode) |-> !status_yellow_r)
    else $error("status yellow outside io-link mode");
  a_valve_off_idle:
    assert property ((!suction_pin) [*8] |-> !valve_suction_r)
    else $error("suction valve on without a suction command");
  a_write_answer:
    assert property ($rose(s_axi_awvalid) && s_axi_wvalid |-> ##[1:4] s_axi_bvalid)
    else $error("write response late");
  a_read_answer:
    assert property ($rose(s_axi_arvalid) |-> ##[1:4] s_axi_rvalid)
    else $error("read data late");
  a_unmapped_read:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h30
      |=> s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_awready_pulse:
    assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  a_wready_pulse:
    assert property (s_axi_wready |=> !s_axi_wready)
    else $error("write data ready held");
endmodule // vcm_monitor_props

bind vcm_monitor vcm_monitor_props u_props (
  .aclk(aclk), .aresetn(aresetn), .ce(ce), .suction_pin(suction_pin),
  .iolink_mode(iolink_mode), .error_code(error_code), .valve_suction_r(valve_suction_r),
  .status_yellow_r(status_yellow_r), .error_display_r(error_display_r),
  .menu_abort_r(menu_abort_r), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid)
);
`default_nettype wire

/* verification/vcm_plant.sv */
// vacuum circuit model: valve raises vacuum, vent or slow leak lowers it
`timescale 1ns/1ns
`default_nettype none
module vcm_plant (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // valve and environment
  input wire logic valve_on,
  input wire logic vent,
  input wire logic [9:0] ceiling,
  // sensor
  output logic [9:0] vacuum_mbar
);
  logic [5:0] div_r;
  always @(posedge aclk) begin
    if (!aresetn) begin
      vacuum_mbar <= 10'h000;
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
      if (valve_on) begin
        if (vacuum_mbar < ceiling) vacuum_mbar <= vacuum_mbar + 10'h001;
      end else if (vent) begin
        // vent models a gross leak, fast enough to make regulation chatter
        vacuum_mbar <= (vacuum_mbar > 10'h004) ? vacuum_mbar - 10'h004 : 10'h000;
      end else if (div_r == 6'h00 && vacuum_mbar != 10'h000) begin
        vacuum_mbar <= vacuum_mbar - 10'h001;
      end
    end
  end
endmodule // vcm_plant
`default_nettype wire

/* verilog/README_none.v */
`timescale 1ns/1ns

/* verilog/vcm_defs.vh */
// constants for the vacuum condition monitor
`ifndef VCM_DEFS_VH
`define VCM_DEFS_VH
// register byte offsets
`define VCM_OFF_CTRL 8'h00
`define VCM_OFF_UPPER 8'h04
`define VCM_OFF_LOWER 8'h08
`define VCM_OFF_MAX_EVAC 8'h0C
`define VCM_OFF_MAX_LEAK 8'h10
`define VCM_OFF_PRESS 8'h14
`define VCM_OFF_STATUS 8'h18
`define VCM_OFF_TIMES 8'h1C
`define VCM_OFF_LEAK 8'h20
`define VCM_OFF_AIR 8'h24
`define VCM_OFF_ENERGY 8'h28
`define VCM_OFF_ERROR 8'h2C
`define VCM_OFF_DYN 8'h30
// control field positions
`define VCM_CTRL_AIR_SAVE 0
`define VCM_CTRL_NO_CONT 1
`define VCM_CTRL_CTRL_MODE 2
`define VCM_CTRL_AUTOSET 3
`define VCM_CTRL_PRESS_VALID 4
// warning bit positions in status
`define VCM_W_SWITCH 0
`define VCM_W_UPPER 1
`define VCM_W_EVAC 2
`define VCM_W_LEAK 3
`define VCM_W_DYN 4
// reset values
`define VCM_RST_CTRL 5'h05
`define VCM_RST_UPPER 10'h2_58
`define VCM_RST_UHYST 10'h0_32
`define VCM_RST_LOWER 10'h1_F4
`define VCM_RST_LHYST 10'h0_32
`define VCM_RST_MAX_EVAC 14'h0_3E8
`define VCM_RST_MAX_LEAK 16'h00_FA
// timing
`define VCM_CLK_HZ 25000000
`define VCM_MS_CYCLES 15'h61A8
`define VCM_SW_WINDOW_MS 12'hB_B7
`define VCM_SW_MAX 4'h6
`define VCM_MAX_EVAC_LIMIT 14'h2_706
`define VCM_DYN_MS 12'h3_E8
`define VCM_DYN_MIN 10'h0_05
`define VCM_LEAK_SAMPLE_MS 7'h64
`define VCM_LEAK_SCALE 6'h0A
`define VCM_SELF_POWER 8'h0A
`define VCM_COIL_POWER 8'h14
`endif

/* verilog/vcm_monitor.v */
// vacuum ejector condition, energy and maintenance monitor with axi4-lite registers
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "vcm_defs.vh"
// How it works
// - over 6 toggles per 3 s: continuous suction
// - switching trip in io-link: warning and yellow
// - switching protection also works in standard io
// - no-continuous setting keeps regulating always
// - upper threshold missed: warning and yellow
// - that warning from phase end to next cycle
// - measure time to lower and evacuation time
// - evacuation time over maximum: warning, yellow
// - zero disables check; above 9.99 s refused
// - slow leak: resume at upper minus hysteresis
// - fast leak resumes; second time continuous, warning
// - dynamic pressure in band: warning and yellow
// - average leakage classified, readable by master
// - autoset stores last values plus margin
// - relative air is active share of cycle
// - absolute air only with supplied pressure
// - absolute air clears at start, updates live
// - relative air and energy latch at start
// - leakage is vacuum decay while suction paused
// - leak and quality clear, moving average
// - monitoring only while in io-link mode
// - error shows code, aborts menu, readable
module vcm_monitor #(
  parameter [14:0] MS_CYCLES = `VCM_MS_CYCLES
) (
  // clock, reset, enable
  input wire aclk,
  input wire aresetn,
  input wire ce,
  // process side
  input wire suction_pin,
  input wire blowoff_pin,
  input wire [9:0] vacuum_mbar,
  input wire iolink_mode,
  input wire [7:0] error_code,
  output reg valve_suction_r,
  output reg valve_blowoff_r,
  output reg status_yellow_r,
  output reg [7:0] error_display_r,
  output reg menu_abort_r,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  // configuration
  reg [4:0] ctrl_r;
  reg [9:0] upper_r, uhyst_r, lower_r, lhyst_r;
  reg [13:0] max_evac_r;
  reg [15:0] max_leak_r, sys_press_r;
  reg [7:0] nozzle_r;
  // pin synchronisers, bit 0 suction, bit 1 blow-off
  reg [1:0] sync1_r, sync2_r, sync3_r, pin_r, pin_d_r;
  // timing and measurement state
  reg [14:0] div_r;
  reg ms_tick_r;
  reg [11:0] win_ms_r;
  reg [3:0] sw_cnt_r;
  reg cont_r, paused_r, reached_r, exceed_r;
  reg [4:0] warn_r;
  reg t0_run_r, t1_run_r;
  reg [15:0] t0_r, t1_r;
  reg [11:0] dyn_ms_r;
  reg [9:0] dyn_r;
  reg [6:0] leak_ms_r;
  reg [9:0] leak_ref_r;
  reg [15:0] leak_avg_r;
  reg leak_any_r;
  reg [1:0] leak_class_r;
  reg [15:0] tot_ms_r, act_ms_r, air_abs_r;
  reg [7:0] air_rel_r;
  reg [31:0] energy_r;
  // bus state
  reg [7:0] awaddr_r;
  reg aw_got_r, w_got_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;

  wire cycle_start = pin_r[0] & ~pin_d_r[0];
  wire cycle_stop = ~pin_r[0] & pin_d_r[0];
  wire regulating = ctrl_r[`VCM_CTRL_AIR_SAVE] & ctrl_r[`VCM_CTRL_CTRL_MODE] & ~cont_r;
  wire valve_next = pin_r[0] & ~(regulating & paused_r);
  wire [9:0] resume_lvl = (upper_r > uhyst_r) ? upper_r - uhyst_r : 10'h0_00;
  wire [9:0] dyn_low = (lower_r > lhyst_r) ? lower_r - lhyst_r : 10'h0_00;
  wire [9:0] drop = (leak_ref_r > vacuum_mbar) ? leak_ref_r - vacuum_mbar : 10'h0_00;
  wire [15:0] leak_now = drop * `VCM_LEAK_SCALE;
  wire [17:0] leak_mix = {2'b00, leak_avg_r} + {1'b0, leak_avg_r, 1'b0} + {2'b00, leak_now};
  wire [15:0] leak_new = leak_any_r ? leak_mix[17:2] : leak_now;
  wire mon = iolink_mode;
  wire [23:0] act_pct = act_ms_r * 8'h64;
  wire [23:0] rel_raw = (tot_ms_r == 16'h0000) ? 24'h00_0000 : act_pct / tot_ms_r;
  wire [23:0] flow_raw = sys_press_r * nozzle_r;
  wire [31:0] energy_now = tot_ms_r * `VCM_SELF_POWER + act_ms_r * `VCM_COIL_POWER;
  wire [15:0] as_leak = leak_avg_r + {2'b00, leak_avg_r[15:2]};
  wire [15:0] as_evac = t1_r + {2'b00, t1_r[15:2]};
  wire aw_fire = aw_got_r & w_got_r & ~s_axi_bvalid;

  // leak class and quality of the running average
  reg [1:0] class_now;
  reg [7:0] quality;
  always @* begin
    if (leak_avg_r < {2'b00, max_leak_r[15:2]}) begin
      class_now = 2'd0;
      quality = 8'h64;
    end else if (leak_avg_r < {1'b0, max_leak_r[15:1]}) begin
      class_now = 2'd1;
      quality = 8'h4B;
    end else if (leak_avg_r <= max_leak_r) begin
      class_now = 2'd2;
      quality = 8'h32;
    end else begin
      class_now = 2'd3;
      quality = 8'h00;
    end
  end

  // byte-lane merge for register writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  wire [31:0] wd_ctrl = merge({27'h0, ctrl_r}, wdata_r, wstrb_r);
  wire [31:0] wd_upper = merge({6'h0, uhyst_r, 6'h0, upper_r}, wdata_r, wstrb_r);
  wire [31:0] wd_lower = merge({6'h0, lhyst_r, 6'h0, lower_r}, wdata_r, wstrb_r);
  wire [31:0] wd_evac = merge({18'h0, max_evac_r}, wdata_r, wstrb_r);
  wire [31:0] wd_leak = merge({16'h0, max_leak_r}, wdata_r, wstrb_r);
  wire [31:0] wd_press = merge({8'h0, nozzle_r, sys_press_r}, wdata_r, wstrb_r);

  // write decode; a refused evacuation limit answers slverr
  reg [1:0] wr_resp;
  always @* begin
    wr_resp = 2'b00;
    if (awaddr_r == `VCM_OFF_CTRL || awaddr_r == `VCM_OFF_UPPER ||
        awaddr_r == `VCM_OFF_LOWER || awaddr_r == `VCM_OFF_MAX_LEAK ||
        awaddr_r == `VCM_OFF_PRESS) begin
      wr_resp = 2'b00;
    end else if (awaddr_r == `VCM_OFF_MAX_EVAC) begin
      if (wd_evac[31:0] > {18'h0, `VCM_MAX_EVAC_LIMIT}) begin
        wr_resp = 2'b10;
      end
    end else if (awaddr_r == `VCM_OFF_STATUS || awaddr_r == `VCM_OFF_TIMES ||
                 awaddr_r == `VCM_OFF_LEAK || awaddr_r == `VCM_OFF_AIR ||
                 awaddr_r == `VCM_OFF_ENERGY || awaddr_r == `VCM_OFF_ERROR ||
                 awaddr_r == `VCM_OFF_DYN) begin
      wr_resp = 2'b00;
    end else begin
      wr_resp = 2'b10;
    end
  end

  // read decode
  reg [31:0] rd_val;
  reg rd_ok;
  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == `VCM_OFF_CTRL) begin
      rd_val = {27'h0, ctrl_r};
    end else if (s_axi_araddr == `VCM_OFF_UPPER) begin
      rd_val = {6'h0, uhyst_r, 6'h0, upper_r};
    end else if (s_axi_araddr == `VCM_OFF_LOWER) begin
      rd_val = {6'h0, lhyst_r, 6'h0, lower_r};
    end else if (s_axi_araddr == `VCM_OFF_MAX_EVAC) begin
      rd_val = {18'h0, max_evac_r};
    end else if (s_axi_araddr == `VCM_OFF_MAX_LEAK) begin
      rd_val = {16'h0, max_leak_r};
    end else if (s_axi_araddr == `VCM_OFF_PRESS) begin
      rd_val = {8'h0, nozzle_r, sys_press_r};
    end else if (s_axi_araddr == `VCM_OFF_STATUS) begin
      rd_val = {24'h0, status_yellow_r, paused_r, cont_r, warn_r};
    end else if (s_axi_araddr == `VCM_OFF_TIMES) begin
      rd_val = {t1_r, t0_r};
    end else if (s_axi_araddr == `VCM_OFF_LEAK) begin
      rd_val = {6'h0, leak_class_r, quality, leak_avg_r};
    end else if (s_axi_araddr == `VCM_OFF_AIR) begin
      rd_val = {air_abs_r, 8'h0, air_rel_r};
    end else if (s_axi_araddr == `VCM_OFF_ENERGY) begin
      rd_val = energy_r;
    end else if (s_axi_araddr == `VCM_OFF_ERROR) begin
      rd_val = {24'h0, error_display_r};
    end else if (s_axi_araddr == `VCM_OFF_DYN) begin
      rd_val = {22'h0, dyn_r};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // axi4-lite handshakes and register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      ctrl_r <= `VCM_RST_CTRL;
      upper_r <= `VCM_RST_UPPER;
      uhyst_r <= `VCM_RST_UHYST;
      lower_r <= `VCM_RST_LOWER;
      lhyst_r <= `VCM_RST_LHYST;
      max_evac_r <= `VCM_RST_MAX_EVAC;
      max_leak_r <= `VCM_RST_MAX_LEAK;
      sys_press_r <= 16'h0000;
      nozzle_r <= 8'h00;
    end else if (ce) begin
      s_axi_awready <= ~aw_got_r & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_got_r & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      ctrl_r[`VCM_CTRL_AUTOSET] <= 1'b0;
      if (aw_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_resp;
        if (awaddr_r == `VCM_OFF_CTRL) begin
          ctrl_r <= wd_ctrl[4:0];
        end else if (awaddr_r == `VCM_OFF_UPPER) begin
          upper_r <= wd_upper[9:0];
          uhyst_r <= wd_upper[25:16];
        end else if (awaddr_r == `VCM_OFF_LOWER) begin
          lower_r <= wd_lower[9:0];
          lhyst_r <= wd_lower[25:16];
        end else if (awaddr_r == `VCM_OFF_MAX_EVAC) begin
          if (wr_resp == 2'b00) begin
            max_evac_r <= wd_evac[13:0];
          end
        end else if (awaddr_r == `VCM_OFF_MAX_LEAK) begin
          max_leak_r <= wd_leak[15:0];
        end else if (awaddr_r == `VCM_OFF_PRESS) begin
          sys_press_r <= wd_press[15:0];
          nozzle_r <= wd_press[23:16];
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // autoset pulse acts one cycle after its write
      if (ctrl_r[`VCM_CTRL_AUTOSET] & mon) begin
        max_leak_r <= as_leak;
        max_evac_r <= (as_evac > {2'b00, `VCM_MAX_EVAC_LIMIT}) ?
                      `VCM_MAX_EVAC_LIMIT : as_evac[13:0];
      end
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // process monitoring
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 2'b00;
      sync2_r <= 2'b00;
      sync3_r <= 2'b00;
      pin_r <= 2'b00;
      pin_d_r <= 2'b00;
      div_r <= 15'h0000;
      ms_tick_r <= 1'b0;
      win_ms_r <= 12'h000;
      sw_cnt_r <= 4'h0;
      cont_r <= 1'b0;
      paused_r <= 1'b0;
      reached_r <= 1'b0;
      exceed_r <= 1'b0;
      warn_r <= 5'h00;
      t0_run_r <= 1'b0;
      t1_run_r <= 1'b0;
      t0_r <= 16'h0000;
      t1_r <= 16'h0000;
      dyn_ms_r <= 12'h000;
      dyn_r <= 10'h0_00;
      leak_ms_r <= 7'h00;
      leak_ref_r <= 10'h0_00;
      leak_avg_r <= 16'h0000;
      leak_any_r <= 1'b0;
      leak_class_r <= 2'd0;
      tot_ms_r <= 16'h0000;
      act_ms_r <= 16'h0000;
      air_abs_r <= 16'h0000;
      air_rel_r <= 8'h00;
      energy_r <= 32'h0000_0000;
      valve_suction_r <= 1'b0;
      valve_blowoff_r <= 1'b0;
      status_yellow_r <= 1'b0;
      error_display_r <= 8'h00;
      menu_abort_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= {blowoff_pin, suction_pin};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r <= (pin_r & (sync2_r ^ sync3_r)) | (sync3_r & ~(sync2_r ^ sync3_r));
      pin_d_r <= pin_r;
      ms_tick_r <= (div_r == MS_CYCLES - 15'h0001);
      div_r <= (div_r == MS_CYCLES - 15'h0001) ? 15'h0000 : div_r + 15'h0001;
      valve_suction_r <= valve_next;
      valve_blowoff_r <= pin_r[1];
      error_display_r <= error_code;
      menu_abort_r <= (error_code != 8'h00) & (error_display_r == 8'h00);
      status_yellow_r <= mon & (warn_r != 5'h00);
      // switching window, active in every mode
      if (ms_tick_r) begin
        win_ms_r <= (win_ms_r == `VCM_SW_WINDOW_MS) ? 12'h000 : win_ms_r + 12'h001;
      end
      if (ms_tick_r & (win_ms_r == `VCM_SW_WINDOW_MS)) begin
        sw_cnt_r <= 4'h0;
      end else if ((valve_next ^ valve_suction_r) & (sw_cnt_r != 4'hF)) begin
        sw_cnt_r <= sw_cnt_r + 4'h1;
      end
      if (sw_cnt_r > `VCM_SW_MAX) begin
        cont_r <= ~ctrl_r[`VCM_CTRL_NO_CONT];
        if (mon) begin
          warn_r[`VCM_W_SWITCH] <= 1'b1;
        end
      end
      if (cycle_stop) begin
        cont_r <= 1'b0;
        paused_r <= 1'b0;
        t0_run_r <= 1'b0;
        t1_run_r <= 1'b0;
        if (!reached_r & mon) begin
          warn_r[`VCM_W_UPPER] <= 1'b1;
        end
      end
      // regulation and leakage on the paused vacuum
      if (pin_r[0] & regulating) begin
        if (!paused_r & (vacuum_mbar >= upper_r)) begin
          paused_r <= 1'b1;
          leak_ref_r <= vacuum_mbar;
          leak_ms_r <= 7'h00;
        end else if (paused_r & (vacuum_mbar < resume_lvl)) begin
          paused_r <= 1'b0;
        end else if (paused_r & ms_tick_r & mon) begin
          leak_ms_r <= leak_ms_r + 7'h01;
          if (leak_ms_r == `VCM_LEAK_SAMPLE_MS - 7'h01) begin
            leak_ms_r <= 7'h00;
            leak_ref_r <= vacuum_mbar;
            leak_avg_r <= leak_new;
            leak_any_r <= 1'b1;
            if (leak_now > max_leak_r) begin
              paused_r <= 1'b0;
              exceed_r <= 1'b1;
              if (exceed_r) begin
                warn_r[`VCM_W_LEAK] <= 1'b1;
                if (!ctrl_r[`VCM_CTRL_NO_CONT]) begin
                  cont_r <= 1'b1;
                end
              end
            end
          end
        end
      end
      if (pin_r[0] & (vacuum_mbar >= upper_r)) begin
        reached_r <= 1'b1;
      end
      // evacuation times
      if (ms_tick_r & t0_run_r & mon) begin
        t0_r <= t0_r + 16'h0001;
      end
      if (t0_run_r & (vacuum_mbar >= lower_r)) begin
        t0_run_r <= 1'b0;
        t1_run_r <= 1'b1;
      end
      if (ms_tick_r & t1_run_r & mon) begin
        t1_r <= t1_r + 16'h0001;
      end
      if (t1_run_r & (vacuum_mbar >= upper_r)) begin
        t1_run_r <= 1'b0;
      end
      if (mon & t1_run_r & (max_evac_r != 14'h0000) & (t1_r > {2'b00, max_evac_r})) begin
        warn_r[`VCM_W_EVAC] <= 1'b1;
      end
      // dynamic pressure after a second of free suction
      if (ms_tick_r & pin_r[0] & (dyn_ms_r != `VCM_DYN_MS)) begin
        dyn_ms_r <= dyn_ms_r + 12'h001;
        if ((dyn_ms_r == `VCM_DYN_MS - 12'h001) & mon &
            (vacuum_mbar >= `VCM_DYN_MIN) & (vacuum_mbar <= upper_r)) begin
          dyn_r <= vacuum_mbar;
          if ((vacuum_mbar > dyn_low) & (vacuum_mbar < upper_r)) begin
            warn_r[`VCM_W_DYN] <= 1'b1;
          end
        end
      end
      // energy and air figures
      if (ms_tick_r & mon) begin
        tot_ms_r <= tot_ms_r + 16'h0001;
        if (valve_suction_r | valve_blowoff_r) begin
          act_ms_r <= act_ms_r + 16'h0001;
          if (ctrl_r[`VCM_CTRL_PRESS_VALID]) begin
            air_abs_r <= air_abs_r + flow_raw[23:8];
          end
        end
      end
      // cycle start: latch the previous cycle, clear the new one
      if (cycle_start) begin
        if (mon) begin
          air_rel_r <= rel_raw[7:0];
          energy_r <= energy_now;
          leak_class_r <= class_now;
        end
        tot_ms_r <= 16'h0000;
        act_ms_r <= 16'h0000;
        air_abs_r <= 16'h0000;
        leak_avg_r <= 16'h0000;
        leak_any_r <= 1'b0;
        exceed_r <= 1'b0;
        reached_r <= 1'b0;
        paused_r <= 1'b0;
        dyn_ms_r <= 12'h000;
        t0_r <= 16'h0000;
        t1_r <= 16'h0000;
        t0_run_r <= 1'b1;
        t1_run_r <= 1'b0;
        warn_r <= warn_r & 5'b00001;
        if (sw_cnt_r > `VCM_SW_MAX) begin
          warn_r[`VCM_W_SWITCH] <= mon;
        end
      end
    end
  end
endmodule // vcm_monitor
`default_nettype wire
